// *** verilog/iep_pkg.sv ***
// constants, types and register map of the interrupt enable/priority block
// assumes one system clock and an sfr bus driven by the cpu core
package iep_pkg;

	localparam int         NUM_SRC                = 15;
	localparam int         IDX_W                  = 4;

	localparam logic [7:0] ADDR_ENABLE_PRIMARY    = 8'hA8;
	localparam logic [7:0] ADDR_PRIORITY_PRIMARY  = 8'hB8;
	localparam logic [7:0] ADDR_ENABLE_EXT_FIRST  = 8'hE6;

	localparam logic [7:0] RST_ENABLE_PRIMARY     = 8'h00;
	localparam logic [7:0] RST_PRIORITY_PRIMARY   = 8'h80;
	localparam logic [7:0] RST_ENABLE_EXT_FIRST   = 8'h00;

	localparam logic [7:0] PRIO_FIXED_ONES        = 8'h80;
	localparam logic [7:0] EXT_FIRST_RW_MASK      = 8'hFD;

	// primary enable register fields
	localparam int BIT_GLOBAL_IRQ_GATE            = 7;
	localparam int BIT_SERIAL_PERIPH_IRQ_EN       = 6;
	localparam int BIT_TIMER2_IRQ_EN              = 5;
	localparam int BIT_ASYNC_SERIAL_IRQ_EN        = 4;
	localparam int BIT_TIMER1_IRQ_EN              = 3;
	localparam int BIT_EXT1_IRQ_EN                = 2;
	localparam int BIT_TIMER0_IRQ_EN              = 1;
	localparam int BIT_EXT0_IRQ_EN                = 0;

	// first extended enable register fields (priority input uses the same)
	localparam int BIT_TIMER3_IRQ_EN              = 7;
	localparam int BIT_COMPARATOR1_IRQ_EN         = 6;
	localparam int BIT_COMPARATOR0_IRQ_EN         = 5;
	localparam int BIT_COUNTER_ARRAY_IRQ_EN       = 4;
	localparam int BIT_ADC_DONE_IRQ_EN            = 3;
	localparam int BIT_ADC_WINDOW_IRQ_EN          = 2;
	localparam int BIT_TWO_WIRE_IRQ_EN            = 0;

	// source index, which is also the fixed arbitration order
	localparam int SRC_EXT0                       = 0;
	localparam int SRC_TIMER0                     = 1;
	localparam int SRC_EXT1                       = 2;
	localparam int SRC_TIMER1                     = 3;
	localparam int SRC_ASYNC_SERIAL               = 4;
	localparam int SRC_TIMER2                     = 5;
	localparam int SRC_SERIAL_PERIPH              = 6;
	localparam int SRC_TWO_WIRE                   = 7;
	localparam int SRC_RESERVED                   = 8;
	localparam int SRC_ADC_WINDOW                 = 9;
	localparam int SRC_ADC_DONE                   = 10;
	localparam int SRC_COUNTER_ARRAY              = 11;
	localparam int SRC_COMPARATOR0                = 12;
	localparam int SRC_COMPARATOR1                = 13;
	localparam int SRC_TIMER3                     = 14;

	typedef enum logic [1:0] {
		SVC_IDLE   = 2'b00,
		SVC_LOW    = 2'b01,
		SVC_NESTED = 2'b11,
		SVC_HIGH   = 2'b10
	} iep_svc_e;

	typedef struct packed {
		logic       rdEn;
		logic       wrEn;
		logic [7:0] addr;
		logic [7:0] wrData;
	} iep_sfr_req_s;

	typedef struct packed {
		logic       en;
		logic [7:0] addr;
		logic       val;
	} iep_bit_wr_s;

	typedef struct packed {
		logic             valid;
		logic             high;
		logic [IDX_W-1:0] index;
	} iep_arb_s;

endpackage : iep_pkg

// *** verilog/iep_regs.sv ***
// interrupt enable and priority registers with request gating and arbiter
// assumes the cpu core drives the sfr ports and source flags on clk
//
// Function
// - global gate clear blocks every request
// - gate set: each source follows its mask
// - enable bit 6 gates serial peripheral unit
// - enable bit 5 gates timer 2 overflows
// - enable bit 4 gates async serial unit
// - enable bit 3 gates timer 1 overflow
// - enable bit 2 gates external input 1
// - enable bit 1 gates timer 0 overflow
// - enable bit 0 gates external input 0
// - extended bit 7 gates timer 3 overflows
// - extended bit 6 gates comparator 1 edges
// - extended bit 5 gates comparator 0 edges
// - extended bit 4 gates counter array unit
// - extended bit 3 gates conversion done
// - extended bit 2 gates window compare
// - extended bit 1 reads zero, ignores writes
// - extended bit 0 gates two wire unit
// - priority bit picks low or high level
// - high preempts low; high never preempted
`timescale 1ns/100ps

module iep_regs (
	input  wire logic                  clk,
	input  wire logic                  rst,
	input  wire iep_pkg::iep_sfr_req_s sfrReq,
	input  wire iep_pkg::iep_bit_wr_s  sfrBitWr,
	output logic [7:0]                 sfrRdData,
	output logic                       sfrRdHit,
	input  wire logic                  extIrq0Input,
	input  wire logic                  timer0OverflowFlag,
	input  wire logic                  extIrq1Input,
	input  wire logic                  timer1OverflowFlag,
	input  wire logic                  asyncSerialIrqFlag,
	input  wire logic                  timer2LowOverflowFlag,
	input  wire logic                  timer2HighOverflowFlag,
	input  wire logic                  serialPeriphIrqFlag,
	input  wire logic                  twoWireIrqFlag,
	input  wire logic                  adcWindowFlag,
	input  wire logic                  adcDoneFlag,
	input  wire logic                  counterArrayIrqFlag,
	input  wire logic                  cmp0RiseFlag,
	input  wire logic                  cmp0FallFlag,
	input  wire logic                  cmp1RiseFlag,
	input  wire logic                  cmp1FallFlag,
	input  wire logic                  timer3LowOverflowFlag,
	input  wire logic                  timer3HighOverflowFlag,
	input  wire logic [7:0]            extPriority,
	input  wire logic                  svcEnter,
	input  wire logic                  svcReturn,
	output logic [14:0]                irqReq,
	output logic [14:0]                irqPrio,
	output iep_pkg::iep_arb_s          irqArb,
	output iep_pkg::iep_svc_e          svcState
);

	logic [7:0]                     enPrim_ff;
	logic [6:0]                     prioPrim_ff;
	logic [7:0]                     enExt_ff;
	logic [7:0]                     sfrRdData_ff;
	logic                           sfrRdHit_ff;
	logic [iep_pkg::NUM_SRC-1:0]    irqReq_ff;
	logic [iep_pkg::NUM_SRC-1:0]    irqPrio_ff;
	iep_pkg::iep_arb_s              irqArb_ff;
	iep_pkg::iep_svc_e              svcState_ff;

	logic                           hitEnPrim;
	logic                           hitPrioPrim;
	logic                           hitEnExt;
	logic                           bitHitEnPrim;
	logic                           bitHitPrioPrim;
	logic [2:0]                     bitSel;
	logic [7:0]                     rdPrio;
	logic [7:0]                     nxt_sfrRdData;
	logic                           nxt_sfrRdHit;
	logic                           globalGate;
	logic [iep_pkg::NUM_SRC-1:0]    pending;
	logic [iep_pkg::NUM_SRC-1:0]    maskVec;
	logic [iep_pkg::NUM_SRC-1:0]    nxt_irqReq;
	logic [iep_pkg::NUM_SRC-1:0]    nxt_irqPrio;
	logic                           hiFound;
	logic                           loFound;
	logic [iep_pkg::IDX_W-1:0]      hiIdx;
	logic [iep_pkg::IDX_W-1:0]      loIdx;
	logic                           allowHigh;
	logic                           allowLow;
	iep_pkg::iep_arb_s              nxt_irqArb;
	iep_pkg::iep_svc_e              midState;
	iep_pkg::iep_svc_e              nxt_svcState;

	// byte decode; bit writes only reach the two bit addressable registers
	assign hitEnPrim   = sfrReq.addr == iep_pkg::ADDR_ENABLE_PRIMARY;
	assign hitPrioPrim = sfrReq.addr == iep_pkg::ADDR_PRIORITY_PRIMARY;
	assign hitEnExt    = sfrReq.addr == iep_pkg::ADDR_ENABLE_EXT_FIRST;
	assign bitSel      = sfrBitWr.addr[2:0];
	assign bitHitEnPrim = sfrBitWr.en &&
		(sfrBitWr.addr[7:3] == iep_pkg::ADDR_ENABLE_PRIMARY[7:3]);
	assign bitHitPrioPrim = sfrBitWr.en &&
		(sfrBitWr.addr[7:3] == iep_pkg::ADDR_PRIORITY_PRIMARY[7:3]);

	// a byte write in the same cycle as a bit write to it wins
	always_ff @(posedge clk) begin
		if (rst) begin
			enPrim_ff <= iep_pkg::RST_ENABLE_PRIMARY;
		end else if (sfrReq.wrEn && hitEnPrim) begin
			enPrim_ff <= sfrReq.wrData;
		end else if (bitHitEnPrim) begin
			enPrim_ff[bitSel] <= sfrBitWr.val;
		end
	end

	// the unused top bit is not stored, so no write can reach it
	always_ff @(posedge clk) begin
		if (rst) begin
			prioPrim_ff <= iep_pkg::RST_PRIORITY_PRIMARY[6:0];
		end else if (sfrReq.wrEn && hitPrioPrim) begin
			prioPrim_ff <= sfrReq.wrData[6:0];
		end else if (bitHitPrioPrim && (bitSel != 3'h7)) begin
			prioPrim_ff[bitSel] <= sfrBitWr.val;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			enExt_ff <= iep_pkg::RST_ENABLE_EXT_FIRST;
		end else if (sfrReq.wrEn && hitEnExt) begin
			enExt_ff <= sfrReq.wrData & iep_pkg::EXT_FIRST_RW_MASK;
		end
	end

	assign rdPrio = iep_pkg::PRIO_FIXED_ONES | {1'b0, prioPrim_ff};

	// unmapped addresses read zero with the hit flag low
	always_comb begin
		nxt_sfrRdData = 8'h00;
		nxt_sfrRdHit  = 1'b0;
		if (sfrReq.rdEn) begin
			if (hitEnPrim) begin
				nxt_sfrRdData = enPrim_ff;
				nxt_sfrRdHit  = 1'b1;
			end else if (hitPrioPrim) begin
				nxt_sfrRdData = rdPrio;
				nxt_sfrRdHit  = 1'b1;
			end else if (hitEnExt) begin
				nxt_sfrRdData = enExt_ff & iep_pkg::EXT_FIRST_RW_MASK;
				nxt_sfrRdHit  = 1'b1;
			end
		end
	end

	// read data holds until the next read so the core may sample late
	always_ff @(posedge clk) begin
		if (rst) begin
			sfrRdData_ff <= 8'h00;
		end else if (sfrReq.rdEn) begin
			sfrRdData_ff <= nxt_sfrRdData;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			sfrRdHit_ff <= 1'b0;
		end else begin
			sfrRdHit_ff <= nxt_sfrRdHit;
		end
	end

	// pending flags; paired flags of one source merge into one request
	always_comb begin
		pending = '0;
		pending[iep_pkg::SRC_EXT0]          = extIrq0Input;
		pending[iep_pkg::SRC_TIMER0]        = timer0OverflowFlag;
		pending[iep_pkg::SRC_EXT1]          = extIrq1Input;
		pending[iep_pkg::SRC_TIMER1]        = timer1OverflowFlag;
		pending[iep_pkg::SRC_ASYNC_SERIAL]  = asyncSerialIrqFlag;
		pending[iep_pkg::SRC_TIMER2]        =
			timer2LowOverflowFlag | timer2HighOverflowFlag;
		pending[iep_pkg::SRC_SERIAL_PERIPH] = serialPeriphIrqFlag;
		pending[iep_pkg::SRC_TWO_WIRE]      = twoWireIrqFlag;
		pending[iep_pkg::SRC_ADC_WINDOW]    = adcWindowFlag;
		pending[iep_pkg::SRC_ADC_DONE]      = adcDoneFlag;
		pending[iep_pkg::SRC_COUNTER_ARRAY] = counterArrayIrqFlag;
		pending[iep_pkg::SRC_COMPARATOR0]   = cmp0RiseFlag | cmp0FallFlag;
		pending[iep_pkg::SRC_COMPARATOR1]   = cmp1RiseFlag | cmp1FallFlag;
		pending[iep_pkg::SRC_TIMER3]        =
			timer3LowOverflowFlag | timer3HighOverflowFlag;
	end

	// per source mask bit; the reserved slot has none and stays blocked
	always_comb begin
		maskVec = '0;
		maskVec[iep_pkg::SRC_EXT0] =
			enPrim_ff[iep_pkg::BIT_EXT0_IRQ_EN];
		maskVec[iep_pkg::SRC_TIMER0] =
			enPrim_ff[iep_pkg::BIT_TIMER0_IRQ_EN];
		maskVec[iep_pkg::SRC_EXT1] =
			enPrim_ff[iep_pkg::BIT_EXT1_IRQ_EN];
		maskVec[iep_pkg::SRC_TIMER1] =
			enPrim_ff[iep_pkg::BIT_TIMER1_IRQ_EN];
		maskVec[iep_pkg::SRC_ASYNC_SERIAL] =
			enPrim_ff[iep_pkg::BIT_ASYNC_SERIAL_IRQ_EN];
		maskVec[iep_pkg::SRC_TIMER2] =
			enPrim_ff[iep_pkg::BIT_TIMER2_IRQ_EN];
		maskVec[iep_pkg::SRC_SERIAL_PERIPH] =
			enPrim_ff[iep_pkg::BIT_SERIAL_PERIPH_IRQ_EN];
		maskVec[iep_pkg::SRC_TWO_WIRE] =
			enExt_ff[iep_pkg::BIT_TWO_WIRE_IRQ_EN];
		maskVec[iep_pkg::SRC_ADC_WINDOW] =
			enExt_ff[iep_pkg::BIT_ADC_WINDOW_IRQ_EN];
		maskVec[iep_pkg::SRC_ADC_DONE] =
			enExt_ff[iep_pkg::BIT_ADC_DONE_IRQ_EN];
		maskVec[iep_pkg::SRC_COUNTER_ARRAY] =
			enExt_ff[iep_pkg::BIT_COUNTER_ARRAY_IRQ_EN];
		maskVec[iep_pkg::SRC_COMPARATOR0] =
			enExt_ff[iep_pkg::BIT_COMPARATOR0_IRQ_EN];
		maskVec[iep_pkg::SRC_COMPARATOR1] =
			enExt_ff[iep_pkg::BIT_COMPARATOR1_IRQ_EN];
		maskVec[iep_pkg::SRC_TIMER3] =
			enExt_ff[iep_pkg::BIT_TIMER3_IRQ_EN];
	end

	// extended priorities live outside; only their bits come in here
	always_comb begin
		nxt_irqPrio = '0;
		nxt_irqPrio[6:0] = prioPrim_ff;
		nxt_irqPrio[iep_pkg::SRC_TWO_WIRE] =
			extPriority[iep_pkg::BIT_TWO_WIRE_IRQ_EN];
		nxt_irqPrio[iep_pkg::SRC_ADC_WINDOW] =
			extPriority[iep_pkg::BIT_ADC_WINDOW_IRQ_EN];
		nxt_irqPrio[iep_pkg::SRC_ADC_DONE] =
			extPriority[iep_pkg::BIT_ADC_DONE_IRQ_EN];
		nxt_irqPrio[iep_pkg::SRC_COUNTER_ARRAY] =
			extPriority[iep_pkg::BIT_COUNTER_ARRAY_IRQ_EN];
		nxt_irqPrio[iep_pkg::SRC_COMPARATOR0] =
			extPriority[iep_pkg::BIT_COMPARATOR0_IRQ_EN];
		nxt_irqPrio[iep_pkg::SRC_COMPARATOR1] =
			extPriority[iep_pkg::BIT_COMPARATOR1_IRQ_EN];
		nxt_irqPrio[iep_pkg::SRC_TIMER3] =
			extPriority[iep_pkg::BIT_TIMER3_IRQ_EN];
	end

	assign globalGate = enPrim_ff[iep_pkg::BIT_GLOBAL_IRQ_GATE];

	generate
		for (genvar i = 0; i < iep_pkg::NUM_SRC; i++) begin : g_gate
			assign nxt_irqReq[i] = globalGate & maskVec[i] & pending[i];
		end
	endgenerate

	always_ff @(posedge clk) begin
		if (rst) begin
			irqReq_ff  <= '0;
			irqPrio_ff <= '0;
		end else begin
			irqReq_ff  <= nxt_irqReq;
			irqPrio_ff <= nxt_irqPrio;
		end
	end

	// lowest index wins within a level; scan runs downward for that
	always_comb begin
		hiFound = 1'b0;
		loFound = 1'b0;
		hiIdx   = '0;
		loIdx   = '0;
		for (int i = iep_pkg::NUM_SRC - 1; i >= 0; i--) begin
			if (nxt_irqReq[i] && nxt_irqPrio[i]) begin
				hiFound = 1'b1;
				hiIdx   = iep_pkg::IDX_W'(i);
			end
			if (nxt_irqReq[i] && !nxt_irqPrio[i]) begin
				loFound = 1'b1;
				loIdx   = iep_pkg::IDX_W'(i);
			end
		end
	end

	// a running high routine admits nothing; a low one admits only high
	assign allowHigh = (svcState_ff == iep_pkg::SVC_IDLE) ||
		(svcState_ff == iep_pkg::SVC_LOW);
	assign allowLow  = svcState_ff == iep_pkg::SVC_IDLE;

	always_comb begin
		nxt_irqArb = '0;
		if (hiFound && allowHigh) begin
			nxt_irqArb.valid = 1'b1;
			nxt_irqArb.high  = 1'b1;
			nxt_irqArb.index = hiIdx;
		end else if (loFound && allowLow) begin
			nxt_irqArb.valid = 1'b1;
			nxt_irqArb.high  = 1'b0;
			nxt_irqArb.index = loIdx;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			irqArb_ff <= '0;
		end else begin
			irqArb_ff <= nxt_irqArb;
		end
	end

	// return is applied first so an entry in the same cycle is not lost
	always_comb begin
		midState = svcState_ff;
		if (svcReturn) begin
			case (svcState_ff)
				iep_pkg::SVC_LOW:    midState = iep_pkg::SVC_IDLE;
				iep_pkg::SVC_HIGH:   midState = iep_pkg::SVC_IDLE;
				iep_pkg::SVC_NESTED: midState = iep_pkg::SVC_LOW;
				default:             midState = iep_pkg::SVC_IDLE;
			endcase
		end
	end

	always_comb begin
		nxt_svcState = midState;
		if (svcEnter && irqArb_ff.valid) begin
			case (midState)
				iep_pkg::SVC_IDLE: begin
					nxt_svcState = irqArb_ff.high ? iep_pkg::SVC_HIGH :
						iep_pkg::SVC_LOW;
				end
				iep_pkg::SVC_LOW: begin
					if (irqArb_ff.high) begin
						nxt_svcState = iep_pkg::SVC_NESTED;
					end
				end
				default: nxt_svcState = midState;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			svcState_ff <= iep_pkg::SVC_IDLE;
		end else begin
			svcState_ff <= nxt_svcState;
		end
	end

	assign sfrRdData = sfrRdData_ff;
	assign sfrRdHit  = sfrRdHit_ff;
	assign irqReq    = irqReq_ff;
	assign irqPrio   = irqPrio_ff;
	assign irqArb    = irqArb_ff;
	assign svcState  = svcState_ff;

endmodule : iep_regs

// *** tb/iep_regs_sva.sv ***
// checker for the interrupt enable/priority block
// assumes it is bound to iep_regs and sees only its ports
`timescale 1ns/100ps
module iep_regs_sva (
	input	wire logic			clk,
	input	wire logic			rst,
	input	wire iep_pkg::iep_sfr_req_s	sfrReq,
	input	wire logic [7:0]		sfrRdData,
	input	wire logic			extIrq0Input,
	input	wire logic			timer2LowOverflowFlag,
	input	wire logic			timer2HighOverflowFlag,
	input	wire logic			svcEnter,
	input	wire logic			svcReturn,
	input	wire logic [14:0]		irqReq,
	input	wire logic [14:0]		irqPrio,
	input	wire iep_pkg::iep_arb_s	irqArb,
	input	wire iep_pkg::iep_svc_e	svcState
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	property p_rst;
		$fell(rst) |-> irqReq == 15'h0000 && svcState == iep_pkg::SVC_IDLE;
	endproperty
	property p_prio7;
		sfrReq.rdEn && sfrReq.addr == 8'hB8 |=> sfrRdData[7];
	endproperty
	property p_ext1;
		sfrReq.rdEn && sfrReq.addr == 8'hE6 |=> !sfrRdData[1];
	endproperty
	property p_ext0;
		irqReq[0] |-> $past(extIrq0Input);
	endproperty
	property p_tmr2;
		irqReq[5] |-> $past(timer2LowOverflowFlag) ||
			$past(timer2HighOverflowFlag);
	endproperty
	// arbiter sees the new state one cycle late, so need two cycles in it
	property p_hold;
		svcState inside {iep_pkg::SVC_HIGH, iep_pkg::SVC_NESTED} &&
		$past(svcState) inside {iep_pkg::SVC_HIGH, iep_pkg::SVC_NESTED}
			|-> !irqArb.valid;
	endproperty
	property p_low;
		svcState == iep_pkg::SVC_LOW && $past(svcState) == iep_pkg::SVC_LOW
			&& irqArb.valid |-> irqArb.high;
	endproperty
	property p_arb;
		irqArb.valid |-> irqReq[irqArb.index] &&
			irqArb.high == irqPrio[irqArb.index];
	endproperty
	property p_enter;
		svcState == iep_pkg::SVC_IDLE && svcEnter && irqArb.valid |=>
			svcState == ($past(irqArb.high) ? iep_pkg::SVC_HIGH
				: iep_pkg::SVC_LOW);
	endproperty
	property p_nest;
		svcState == iep_pkg::SVC_NESTED && svcReturn && !svcEnter |=>
			svcState == iep_pkg::SVC_LOW;
	endproperty
	a_rst: assert property (p_rst) else $error("bad reset state");
	a_prio7: assert property (p_prio7) else $error("prio bit7 low");
	a_ext1: assert property (p_ext1) else $error("ext bit1 high");
	a_ext0: assert property (p_ext0) else $error("ext0 req no flag");
	a_tmr2: assert property (p_tmr2) else $error("tmr2 req no flag");
	a_hold: assert property (p_hold) else $error("high preempted");
	a_low: assert property (p_low) else $error("low preempts low");
	a_arb: assert property (p_arb) else $error("arb mismatch");
	a_enter: assert property (p_enter) else $error("bad entry");
	a_nest: assert property (p_nest) else $error("bad nest return");
	c_nest: cover property (svcState == iep_pkg::SVC_NESTED);
	c_high: cover property (svcState == iep_pkg::SVC_HIGH);
	c_tmr2: cover property (irqReq[5]);
endmodule : iep_regs_sva

bind iep_regs iep_regs_sva i_sva (
	.clk(clk),
	.rst(rst),
	.sfrReq(sfrReq),
	.sfrRdData(sfrRdData),
	.extIrq0Input(extIrq0Input),
	.timer2LowOverflowFlag(timer2LowOverflowFlag),
	.timer2HighOverflowFlag(timer2HighOverflowFlag),
	.svcEnter(svcEnter),
	.svcReturn(svcReturn),
	.irqReq(irqReq),
	.irqPrio(irqPrio),
	.irqArb(irqArb),
	.svcState(svcState)
);

// *** tb/iep_periph_model.sv ***
// peripheral pending-flag model for the interrupt block
// assumes the bench picks the raised flags; they show one edge later
`timescale 1ns/100ps
module iep_periph_model (
	input	wire logic		clk,
	input	wire logic		rst,
	input	wire logic [17:0]	raise,
	output	logic [17:0]		pend_ff
);
	// flags stay up until lowered, as software clears them
	always_ff @(posedge clk) begin
		if (rst) begin
			pend_ff <= 18'h0_0000;
		end else begin
			pend_ff <= raise;
		end
	end
endmodule : iep_periph_model

// *** tb/iep_regs_tb.sv ***
// self-checking bench for the interrupt enable/priority block
// assumes the flag model and the bound checker alongside
`timescale 1ns/100ps
module iep_regs_tb;
	localparam int SRC_OF [18] = '{0, 1, 2, 3, 4, 5, 5, 6, 7, 9, 10, 11, 12,
		12, 13, 13, 14, 14};
	logic			clk = 1'b0;
	logic			rst = 1'b1;
	iep_pkg::iep_sfr_req_s	sfrReq = '0;
	iep_pkg::iep_bit_wr_s	sfrBitWr = '0;
	logic [7:0]		extPriority = 8'h00;
	logic			svcEnter = 1'b0;
	logic			svcReturn = 1'b0;
	logic [17:0]		raise = 18'h0_0000;
	logic [17:0]		pend;
	logic [7:0]		sfrRdData;
	logic			sfrRdHit;
	logic [14:0]		irqReq;
	logic [14:0]		irqPrio;
	iep_pkg::iep_arb_s	irqArb;
	iep_pkg::iep_svc_e	svcState;
	int			mismatches = 0;
	int			comparisons = 0;

	always #10 clk = ~clk;

	iep_periph_model i_src (.clk(clk), .rst(rst), .raise(raise),
		.pend_ff(pend));

	iep_regs i_dut (
		.clk(clk),
		.rst(rst),
		.sfrReq(sfrReq),
		.sfrBitWr(sfrBitWr),
		.sfrRdData(sfrRdData),
		.sfrRdHit(sfrRdHit),
		.extIrq0Input(pend[0]),
		.timer0OverflowFlag(pend[1]),
		.extIrq1Input(pend[2]),
		.timer1OverflowFlag(pend[3]),
		.asyncSerialIrqFlag(pend[4]),
		.timer2LowOverflowFlag(pend[5]),
		.timer2HighOverflowFlag(pend[6]),
		.serialPeriphIrqFlag(pend[7]),
		.twoWireIrqFlag(pend[8]),
		.adcWindowFlag(pend[9]),
		.adcDoneFlag(pend[10]),
		.counterArrayIrqFlag(pend[11]),
		.cmp0RiseFlag(pend[12]),
		.cmp0FallFlag(pend[13]),
		.cmp1RiseFlag(pend[14]),
		.cmp1FallFlag(pend[15]),
		.timer3LowOverflowFlag(pend[16]),
		.timer3HighOverflowFlag(pend[17]),
		.extPriority(extPriority),
		.svcEnter(svcEnter),
		.svcReturn(svcReturn),
		.irqReq(irqReq),
		.irqPrio(irqPrio),
		.irqArb(irqArb),
		.svcState(svcState)
	);

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk

	task automatic end_of_test;
		if (mismatches == 0 && comparisons > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : end_of_test

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		sfrReq <= '{1'b0, 1'b1, a, d};
		@(posedge clk);
		sfrReq <= '0;
	endtask : wr

	task automatic bw(input logic [7:0] a, input logic v);
		@(posedge clk);
		sfrBitWr <= '{1'b1, a, v};
		@(posedge clk);
		sfrBitWr <= '0;
	endtask : bw

	task automatic rd(input logic [7:0] a, input logic [7:0] e,
		input logic h);
		@(posedge clk);
		sfrReq <= '{1'b1, 1'b0, a, 8'h00};
		@(posedge clk);
		sfrReq <= '0;
		#1;
		chk({8'h00, sfrRdData}, {8'h00, e});
		chk({15'h0000, sfrRdHit}, {15'h0000, h});
		// the hit flag is a one cycle pulse
		@(posedge clk);
		#1;
		chk({15'h0000, sfrRdHit}, 16'h0000);
	endtask : rd

	// flag model plus design register make two cycles; one spare
	task automatic settle;
		repeat (3) @(posedge clk);
		#1;
	endtask : settle

	task automatic pulse(input logic e, input logic r);
		@(posedge clk);
		svcEnter <= e;
		svcReturn <= r;
		@(posedge clk);
		svcEnter <= 1'b0;
		svcReturn <= 1'b0;
		settle;
	endtask : pulse

	task automatic t_reset;
		rd(8'hA8, 8'h00, 1'b1);
		rd(8'hB8, 8'h80, 1'b1);
		rd(8'hE6, 8'h00, 1'b1);
		rd(8'h55, 8'h00, 1'b0);
	endtask : t_reset

	task automatic t_regs;
		wr(8'hB8, 8'h00);
		rd(8'hB8, 8'h80, 1'b1);
		bw(8'hB9, 1'b1);
		rd(8'hB8, 8'h82, 1'b1);
		wr(8'hB8, 8'hFF);
		bw(8'hBF, 1'b0);
		rd(8'hB8, 8'hFF, 1'b1);
		wr(8'hE6, 8'hFF);
		rd(8'hE6, 8'hFD, 1'b1);
		wr(8'hA8, 8'hFF);
		rd(8'hA8, 8'hFF, 1'b1);
		wr(8'hA8, 8'h00);
		bw(8'hAF, 1'b1);
		rd(8'hA8, 8'h80, 1'b1);
		wr(8'hE6, 8'h00);
	endtask : t_regs

	task automatic t_gate;
		int src;
		logic [7:0] pm;
		logic [7:0] em;
		for (int f = 0; f < 18; f++) begin
			src = SRC_OF[f];
			pm = (src < 7) ? 8'h01 << src : 8'h00;
			em = (src < 7) ? 8'h00 : 8'h01 << ((src == 7) ? 0 : src - 7);
			wr(8'hA8, pm | 8'h80);
			wr(8'hE6, em);
			raise <= 18'h0_0001 << f;
			settle;
			chk({1'b0, irqReq}, 16'h0001 << src);
			chk({1'b0, irqReq}, 16'h0001 << src);
			wr(8'hA8, pm);
			settle;
			chk({1'b0, irqReq}, 16'h0000);
			wr(8'hA8, 8'h80);
			wr(8'hE6, 8'h00);
			settle;
			chk({1'b0, irqReq}, 16'h0000);
			@(posedge clk);
			raise <= 18'h0_0000;
		end
	endtask : t_gate

	task automatic t_prio;
		wr(8'hB8, 8'h7F);
		extPriority <= 8'hA5;
		settle;
		chk({1'b0, irqPrio}, 16'h52FF);
		@(posedge clk);
		extPriority <= 8'h00;
		// two high requests: lowest index wins; then high beats lower low
		wr(8'hA8, 8'h8C);
		raise <= 18'h0_000C;
		settle;
		chk({10'h000, irqArb}, 16'h0032);
		wr(8'hB8, 8'h08);
		settle;
		chk({10'h000, irqArb}, 16'h0033);
		@(posedge clk);
		raise <= 18'h0_0000;
		wr(8'hA8, 8'h00);
	endtask : t_prio

	task automatic t_svc;
		wr(8'hB8, 8'h02);
		wr(8'hA8, 8'h83);
		raise <= 18'h0_0001;
		settle;
		chk({10'h000, irqArb}, 16'h0020);
		pulse(1'b1, 1'b0);
		chk({14'h0000, svcState}, {14'h0000, iep_pkg::SVC_LOW});
		chk({15'h0000, irqArb.valid}, 16'h0000);
		@(posedge clk);
		raise <= 18'h0_0003;
		settle;
		chk({10'h000, irqArb}, 16'h0031);
		pulse(1'b1, 1'b0);
		chk({14'h0000, svcState}, {14'h0000, iep_pkg::SVC_NESTED});
		pulse(1'b0, 1'b1);
		chk({14'h0000, svcState}, {14'h0000, iep_pkg::SVC_LOW});
		pulse(1'b0, 1'b1);
		chk({14'h0000, svcState}, {14'h0000, iep_pkg::SVC_IDLE});
		pulse(1'b1, 1'b0);
		chk({14'h0000, svcState}, {14'h0000, iep_pkg::SVC_HIGH});
		chk({15'h0000, irqArb.valid}, 16'h0000);
		pulse(1'b0, 1'b1);
		@(posedge clk);
		raise <= 18'h0_0000;
	endtask : t_svc

	initial begin
		repeat (20000) @(posedge clk);
		mismatches++;
		end_of_test;
	end

	initial begin
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		t_reset;
		t_regs;
		t_gate;
		t_prio;
		t_svc;
		end_of_test;
	end
endmodule : iep_regs_tb
